// ### motion_cmp_pkg.sv
// constants, register map and shared types of the motion status comparators
package motion_cmp_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 100;
   localparam int MS_IN_NS       = 1000000;
   localparam int CYCLES_PER_MS  = (MS_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int PARAM_W    = 16;
   localparam int NUM_PARAMS = 11;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int NUM_FLAGS  = 7;

   // ----------------------------------------------------------------
   // parameter register indices (byte offset is four times the index)
   // ----------------------------------------------------------------
   localparam int IDX_COND_SEL   = 0;
   localparam int IDX_DONE_THR   = 1;
   localparam int IDX_NEAR_THR   = 2;
   localparam int IDX_WIN_MS     = 3;
   localparam int IDX_HOLD_MS    = 4;
   localparam int IDX_ROT_THR    = 5;
   localparam int IDX_MATCH_THR  = 6;
   localparam int IDX_SNEAR_THR  = 7;
   localparam int IDX_STILL_THR  = 8;
   localparam int IDX_TRQ_THR    = 9;
   localparam int IDX_TRQ_HYS    = 10;

   localparam logic [ADDR_W-1:0] OFF_FLAGS      = 8'h2c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h38;
   localparam logic [ADDR_W-1:0] OFF_LAST_PARAM = 8'h28;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [PARAM_W-1:0] PARAM_RST [NUM_PARAMS] = '{
      16'h0000, 16'h0320, 16'h1388, 16'h000a, 16'h0064, 16'h0014,
      16'h000a, 16'h0064, 16'h000a, 16'h0064, 16'h000a};

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      COND_DEV_ONLY  = 2'h0,
      COND_CMD_ZERO  = 2'h1,
      COND_FILT_ZERO = 2'h2,
      COND_DWELL     = 2'h3
   } cond_mode_e;

   typedef struct packed {
      logic torque_reached;
      logic standstill_flag;
      logic speed_near_flag;
      logic speed_match_flag;
      logic motor_rotating_flag;
      logic pos_near;
      logic pos_done;
   } flags_s;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : motion_cmp_pkg

// ### ms_tick_gen.sv
// one-cycle pulse every millisecond
`timescale 1ns/1ps
module ms_tick_gen #(
   parameter int CYCLES = motion_cmp_pkg::CYCLES_PER_MS
) (
   input  wire logic clk,
   input  wire logic rst,
   output logic      tick
);
   import motion_cmp_pkg::*;

   logic [31:0] cnt_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 32'h0;
         tick  <= 1'b0;
      end else if (cnt_r == 32'(CYCLES - 1)) begin
         cnt_r <= 32'h0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         tick  <= 1'b0;
      end
   end

endmodule : ms_tick_gen

// ### dwell_filter.sv
// persistence window and hold-off stretch for one positioning indication
`timescale 1ns/1ps
module dwell_filter #(
   parameter int W = motion_cmp_pkg::PARAM_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         enable,
   input  wire logic         cond,
   input  wire logic         tick,
   input  wire logic [W-1:0] win_ms,
   input  wire logic [W-1:0] hold_ms,
   output logic              out
);
   import motion_cmp_pkg::*;

   logic [W-1:0] win_cnt_r;
   logic [W-1:0] hold_cnt_r;

   // counts whole ms ticks, so a window is met within one ms of its figure
   always_ff @(posedge clk) begin
      if (rst) begin
         out        <= 1'b0;
         win_cnt_r  <= '0;
         hold_cnt_r <= '0;
      end else if (!enable) begin
         out        <= cond;
         win_cnt_r  <= '0;
         hold_cnt_r <= '0;
      end else if (cond) begin
         hold_cnt_r <= '0;
         if (!out && win_cnt_r >= win_ms) begin
            out <= 1'b1;
         end else if (!out && tick) begin
            win_cnt_r <= win_cnt_r + 1'b1;
         end
      end else begin
         win_cnt_r <= '0;
         if (out && hold_cnt_r >= hold_ms) begin
            out        <= 1'b0;
            hold_cnt_r <= '0;
         end else if (out && tick) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
         end
      end
   end

endmodule : dwell_filter

// ### motion_status_comparators.sv
// motion status comparators with AXI4-Lite parameter and interrupt registers
//
// Functional notes
// R1: in position mode, positioning flags follow absolute deviation against thresholds
// R2: code 0: flag depends only on deviation at or below threshold
// R3: code 1: position command must also be zero
// R4: code 2: filtered position command must also be zero
// R5: code 3: deviation and zero filtered command must persist the window time
// R6: completion threshold register, default 800, range 1 to 65535
// R7: separate approach threshold register, default 5000
// R8: detection window time in ms, default 10, range 0 to 20000
// R9: code 3: flag held for hold time ms after positioning, default 100
// R10: rotating flag uses rpm threshold, default 20, range 0 to 1000
// R11: speed match when actual is within threshold of command, default 10
// R12: speed approach when actual speed reaches threshold, default 100
// R13: standstill threshold in rpm, default 10, max 6000
// R14: torque threshold default 100 percent and hysteresis default 10 percent
// R15: torque flag sets at threshold, clears below threshold minus hysteresis
// R16: standstill at or below threshold, rotating above its threshold
`timescale 1ns/1ps
module motion_status_comparators #(
   parameter int DEV_W         = 32,
   parameter int SPD_W         = 16,
   parameter int TRQ_W         = 16,
   parameter int CYCLES_PER_MS = motion_cmp_pkg::CYCLES_PER_MS
) (
   input  wire logic                                REF_CLK,
   input  wire logic                                RST,
   // axi4-lite slave
   input  wire logic [motion_cmp_pkg::ADDR_W-1:0]   AWADDR,
   input  wire logic                                AWVALID,
   output logic                                     AWREADY,
   input  wire logic [motion_cmp_pkg::DATA_W-1:0]   WDATA,
   input  wire logic [3:0]                          WSTRB,
   input  wire logic                                WVALID,
   output logic                                     WREADY,
   output logic [1:0]                               BRESP,
   output logic                                     BVALID,
   input  wire logic                                BREADY,
   input  wire logic [motion_cmp_pkg::ADDR_W-1:0]   ARADDR,
   input  wire logic                                ARVALID,
   output logic                                     ARREADY,
   output logic [motion_cmp_pkg::DATA_W-1:0]        RDATA,
   output logic [1:0]                               RRESP,
   output logic                                     RVALID,
   input  wire logic                                RREADY,
   // measured values from the control loop
   input  wire logic                                POS_MODE,
   input  wire logic signed [DEV_W-1:0]             POS_DEV,
   input  wire logic signed [DEV_W-1:0]             POS_CMD,
   input  wire logic signed [DEV_W-1:0]             POS_CMD_FILT,
   input  wire logic signed [SPD_W-1:0]             SPD_ACT,
   input  wire logic signed [SPD_W-1:0]             SPD_CMD,
   input  wire logic signed [TRQ_W-1:0]             TORQUE,
   // status
   output motion_cmp_pkg::flags_s                   MOTION_FLAGS,
   output logic                                     IRQ
);
   import motion_cmp_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [DEV_W-1:0] abs_dev(input logic signed [DEV_W-1:0] v);
      abs_dev = v[DEV_W-1] ? DEV_W'(-v) : DEV_W'(v);
   endfunction : abs_dev

   function automatic logic [SPD_W:0] abs_spd(input logic signed [SPD_W:0] v);
      abs_spd = v[SPD_W] ? (SPD_W+1)'(-v) : (SPD_W+1)'(v);
   endfunction : abs_spd

   // register index of a parameter offset, or NUM_PARAMS when none
   function automatic int param_index(input logic [ADDR_W-1:0] a);
      if (a[1:0] == 2'h0 && a <= OFF_LAST_PARAM) begin
         param_index = int'(a[ADDR_W-1:2]);
      end else begin
         param_index = NUM_PARAMS;
      end
   endfunction : param_index

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [PARAM_W-1:0]   param_r [NUM_PARAMS];
   logic [NUM_FLAGS-1:0] irq_status_r;
   logic [NUM_FLAGS-1:0] irq_enable_r;
   logic [NUM_FLAGS-1:0] flags_prev_r;
   logic                 aw_have_r;
   logic                 w_have_r;
   logic [ADDR_W-1:0]    awaddr_r;
   logic [DATA_W-1:0]    wdata_r;
   logic [3:0]           wstrb_r;
   logic                 aw_hs;
   logic                 w_hs;
   logic                 do_write;
   logic [ADDR_W-1:0]    wr_addr;
   logic [DATA_W-1:0]    wr_data;
   logic [3:0]           wr_strb;
   logic                 wr_clear;
   logic [NUM_FLAGS-1:0] clear_bits;
   logic [NUM_FLAGS-1:0] rise_bits;
   logic                 ms_tick;
   logic                 dwell_en;
   logic                 cmd_ok;
   logic                 done_cond;
   logic                 near_cond;
   logic                 done_dwell;
   logic                 near_dwell;
   logic [DEV_W-1:0]     dev_mag;
   logic [SPD_W:0]       spd_mag;
   logic [SPD_W:0]       spd_err_mag;
   logic [TRQ_W:0]       trq_mag;
   logic [TRQ_W:0]       trq_release;
   logic                 trq_reached_r;
   flags_s               flags_nxt;
   cond_mode_e           cond_mode;

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   assign aw_hs    = AWVALID && AWREADY;
   assign w_hs     = WVALID && WREADY;
   assign do_write = (aw_have_r || aw_hs) && (w_have_r || w_hs) && !BVALID;
   assign wr_addr  = aw_have_r ? awaddr_r : AWADDR;
   assign wr_data  = w_have_r ? wdata_r : WDATA;
   assign wr_strb  = w_have_r ? wstrb_r : WSTRB;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         aw_have_r <= 1'b0;
         awaddr_r  <= '0;
         AWREADY   <= 1'b1;
      end else if (do_write) begin
         aw_have_r <= 1'b0;
         AWREADY   <= 1'b0;
      end else if (aw_hs) begin
         aw_have_r <= 1'b1;
         awaddr_r  <= AWADDR;
         AWREADY   <= 1'b0;
      end else if (BVALID && BREADY) begin
         AWREADY   <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         w_have_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= 4'h0;
         WREADY   <= 1'b1;
      end else if (do_write) begin
         w_have_r <= 1'b0;
         WREADY   <= 1'b0;
      end else if (w_hs) begin
         w_have_r <= 1'b1;
         wdata_r  <= WDATA;
         wstrb_r  <= WSTRB;
         WREADY   <= 1'b0;
      end else if (BVALID && BREADY) begin
         WREADY   <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         BVALID <= 1'b0;
         BRESP  <= RESP_OKAY;
      end else if (do_write) begin
         BVALID <= 1'b1;
         BRESP  <= (param_index(wr_addr) < NUM_PARAMS || wr_addr == OFF_IRQ_CLEAR
                    || wr_addr == OFF_IRQ_ENABLE) ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // parameter registers, byte lanes 0 and 1 only
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      for (int i = 0; i < NUM_PARAMS; i++) begin
         if (RST) begin
            param_r[i] <= PARAM_RST[i]; // see R6 // see R7 // see R8 // see R14
         end else if (do_write && param_index(wr_addr) == i) begin
            if (wr_strb[0]) begin
               param_r[i][7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
               param_r[i][15:8] <= wr_data[15:8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ARREADY <= 1'b1;
         RVALID  <= 1'b0;
         RDATA   <= '0;
         RRESP   <= RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b1;
         RRESP   <= RESP_OKAY;
         RDATA   <= '0;
         if (param_index(ARADDR) < NUM_PARAMS) begin
            RDATA <= {16'h0, param_r[param_index(ARADDR)]};
         end else if (ARADDR == OFF_FLAGS) begin
            RDATA <= {25'h0, MOTION_FLAGS};
         end else if (ARADDR == OFF_IRQ_STATUS) begin
            RDATA <= {25'h0, irq_status_r};
         end else if (ARADDR == OFF_IRQ_ENABLE) begin
            RDATA <= {25'h0, irq_enable_r};
         end else if (ARADDR != OFF_IRQ_CLEAR) begin
            RRESP <= RESP_SLVERR;
         end
      end else if (RVALID && RREADY) begin
         RVALID  <= 1'b0;
         ARREADY <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, clear and enable
   // ----------------------------------------------------------------
   assign wr_clear   = do_write && wr_addr == OFF_IRQ_CLEAR && wr_strb[0];
   assign clear_bits = wr_clear ? wr_data[NUM_FLAGS-1:0] : '0;
   assign rise_bits  = MOTION_FLAGS & ~flags_prev_r;

   // a rising flag in the clearing cycle stays set
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         irq_status_r <= '0;
         flags_prev_r <= '0;
      end else begin
         irq_status_r <= (irq_status_r & ~clear_bits) | rise_bits;
         flags_prev_r <= MOTION_FLAGS;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         irq_enable_r <= '0;
      end else if (do_write && wr_addr == OFF_IRQ_ENABLE && wr_strb[0]) begin
         irq_enable_r <= wr_data[NUM_FLAGS-1:0];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_status_r & irq_enable_r);
      end
   end

   // ----------------------------------------------------------------
   // positioning comparators
   // ----------------------------------------------------------------
   assign cond_mode = cond_mode_e'(param_r[IDX_COND_SEL][1:0]);
   assign dev_mag   = abs_dev(POS_DEV);

   always_comb begin
      case (cond_mode)
         COND_DEV_ONLY:  cmd_ok = 1'b1;                   // see R2
         COND_CMD_ZERO:  cmd_ok = (POS_CMD == '0);        // see R3
         COND_FILT_ZERO: cmd_ok = (POS_CMD_FILT == '0);   // see R4
         COND_DWELL:     cmd_ok = (POS_CMD_FILT == '0);   // see R5
         default:        cmd_ok = 1'b1;
      endcase
   end

   // see R1
   assign done_cond = POS_MODE && cmd_ok
                      && dev_mag <= DEV_W'(param_r[IDX_DONE_THR]); // see R6
   assign near_cond = POS_MODE && cmd_ok
                      && dev_mag <= DEV_W'(param_r[IDX_NEAR_THR]); // see R7
   assign dwell_en  = (cond_mode == COND_DWELL);

   ms_tick_gen #(
      .CYCLES (CYCLES_PER_MS)
   ) u_ms_tick (
      .clk  (REF_CLK),
      .rst  (RST),
      .tick (ms_tick)
   );

   // window then hold, each in whole milliseconds
   dwell_filter #(
      .W (PARAM_W)
   ) u_done_dwell (
      .clk     (REF_CLK),
      .rst     (RST),
      .enable  (dwell_en),
      .cond    (done_cond),
      .tick    (ms_tick),
      .win_ms  (param_r[IDX_WIN_MS]),   // see R5 // see R8
      .hold_ms (param_r[IDX_HOLD_MS]),  // see R9
      .out     (done_dwell)
   );

   dwell_filter #(
      .W (PARAM_W)
   ) u_near_dwell (
      .clk     (REF_CLK),
      .rst     (RST),
      .enable  (dwell_en),
      .cond    (near_cond),
      .tick    (ms_tick),
      .win_ms  (param_r[IDX_WIN_MS]),   // see R5
      .hold_ms (param_r[IDX_HOLD_MS]),  // see R9
      .out     (near_dwell)
   );

   // ----------------------------------------------------------------
   // speed and torque comparators
   // ----------------------------------------------------------------
   assign spd_mag     = abs_spd((SPD_W+1)'(SPD_ACT));
   assign spd_err_mag = abs_spd((SPD_W+1)'(SPD_ACT) - (SPD_W+1)'(SPD_CMD));
   assign trq_mag     = abs_spd((TRQ_W+1)'(TORQUE));
   // saturate so a hysteresis above the threshold gives release level zero, so the flag never clears
   assign trq_release = (param_r[IDX_TRQ_HYS] > param_r[IDX_TRQ_THR]) ? '0 :
                        (TRQ_W+1)'(param_r[IDX_TRQ_THR] - param_r[IDX_TRQ_HYS]);

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         trq_reached_r <= 1'b0;
      end else if (trq_mag >= (TRQ_W+1)'(param_r[IDX_TRQ_THR])) begin
         trq_reached_r <= 1'b1; // see R15
      end else if (trq_mag < trq_release) begin
         trq_reached_r <= 1'b0; // see R15
      end
   end

   always_comb begin
      flags_nxt                     = '0;
      flags_nxt.pos_done            = POS_MODE && (dwell_en ? done_dwell : done_cond); // see R1
      flags_nxt.pos_near            = POS_MODE && (dwell_en ? near_dwell : near_cond); // see R1
      flags_nxt.motor_rotating_flag = spd_mag > (SPD_W+1)'(param_r[IDX_ROT_THR]);   // see R10
      flags_nxt.speed_match_flag    = spd_err_mag
                                      <= (SPD_W+1)'(param_r[IDX_MATCH_THR]);      // see R11
      flags_nxt.speed_near_flag     = spd_mag >= (SPD_W+1)'(param_r[IDX_SNEAR_THR]); // see R12
      flags_nxt.standstill_flag     = spd_mag <= (SPD_W+1)'(param_r[IDX_STILL_THR]); // see R13
      flags_nxt.torque_reached      = trq_reached_r;
   end

   // see R16
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         MOTION_FLAGS <= '0;
      end else begin
         MOTION_FLAGS <= flags_nxt;
      end
   end

endmodule : motion_status_comparators

// ### servo_loop_model.sv
// behavioural servo control loop feeding measured values
`timescale 1ns/1ps
module servo_loop_model (
   input  wire logic         REF_CLK,
   output logic              POS_MODE,
   output logic signed [31:0] POS_DEV,
   output logic signed [31:0] POS_CMD,
   output logic signed [31:0] POS_CMD_FILT,
   output logic signed [15:0] SPD_ACT,
   output logic signed [15:0] SPD_CMD,
   output logic signed [15:0] TORQUE
);
   // loop values always driven: a real loop never floats them
   initial begin
      POS_MODE = 1'b0;
      POS_DEV = '0;
      POS_CMD = '0;
      POS_CMD_FILT = '0;
      SPD_ACT = '0;
      SPD_CMD = '0;
      TORQUE = '0;
   end

   task automatic set(input int m, d, c, f, s, sc, t);
      @(posedge REF_CLK);
      POS_MODE <= m[0];
      POS_DEV <= d;
      POS_CMD <= c;
      POS_CMD_FILT <= f;
      SPD_ACT <= 16'(s);
      SPD_CMD <= 16'(sc);
      TORQUE <= 16'(t);
   endtask : set
endmodule : servo_loop_model

// ### motion_status_comparators_asserts.sv
// port assertions for the motion status comparators
`timescale 1ns/1ps
module motion_status_comparators_asserts
   import motion_cmp_pkg::*;
#(
   parameter int SPD_W = 16
) (
   input wire logic                    REF_CLK,
   input wire logic                    RST,
   input wire logic                    AWVALID,
   input wire logic                    AWREADY,
   input wire logic                    WVALID,
   input wire logic                    WREADY,
   input wire logic                    BVALID,
   input wire logic                    BREADY,
   input wire logic                    ARVALID,
   input wire logic                    ARREADY,
   input wire logic                    RVALID,
   input wire logic                    RREADY,
   input wire logic                    POS_MODE,
   input wire logic signed [SPD_W-1:0] SPD_ACT,
   input wire logic signed [SPD_W-1:0] SPD_CMD,
   input wire flags_s                  MOTION_FLAGS,
   input wire logic                    IRQ
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   property p_reset_quiet;
      $fell(RST) |-> MOTION_FLAGS == '0 && !IRQ && !BVALID && !RVALID;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs not quiet after reset");
   property p_pos_off;
      !POS_MODE |=> !MOTION_FLAGS.pos_done && !MOTION_FLAGS.pos_near;
   endproperty
   a_pos_off: assert property (p_pos_off)
      else $error("positioning flag outside position mode");
   property p_still;
      SPD_ACT == '0 |=> MOTION_FLAGS.standstill_flag;
   endproperty
   a_still: assert property (p_still)
      else $error("standstill missing at zero speed");
   property p_rot;
      SPD_ACT == '0 |=> !MOTION_FLAGS.motor_rotating_flag;
   endproperty
   a_rot: assert property (p_rot)
      else $error("rotating flag at zero speed");
   property p_match;
      SPD_ACT == SPD_CMD |=> MOTION_FLAGS.speed_match_flag;
   endproperty
   a_match: assert property (p_match)
      else $error("speed match missing at equal speeds");
   property p_wr_resp;
      AWVALID && AWREADY && WVALID && WREADY |=> BVALID && !AWREADY && !WREADY;
   endproperty
   a_wr_resp: assert property (p_wr_resp)
      else $error("write response not raised");
   property p_wr_done;
      BVALID && BREADY |=> !BVALID ##0 AWREADY && WREADY;
   endproperty
   a_wr_done: assert property (p_wr_done)
      else $error("write channel not released");
   property p_rd_resp;
      ARVALID && ARREADY |=> RVALID && !ARREADY ##1 RVALID || ARREADY;
   endproperty
   a_rd_resp: assert property (p_rd_resp)
      else $error("read response wrong");
endmodule : motion_status_comparators_asserts

bind motion_status_comparators motion_status_comparators_asserts #(.SPD_W(SPD_W)) u_asserts (.*);

// ### motion_status_comparators_tb.sv
// self-checking bench for the motion status comparators
`timescale 1ns/1ps
module motion_status_comparators_tb;
   import motion_cmp_pkg::*;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic               REF_CLK = 1'b0;
   logic               RST = 1'b1;
   logic [7:0]         AWADDR = '0, ARADDR = '0;
   logic [31:0]        WDATA = '0;
   logic [3:0]         WSTRB = 4'hf;
   logic               AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic               AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
   logic [1:0]         BRESP, RRESP, bq[$];
   logic [31:0]        RDATA, v;
   logic               POS_MODE, irq_exp = 1'b0;
   logic signed [31:0] POS_DEV, POS_CMD, POS_CMD_FILT;
   logic signed [15:0] SPD_ACT, SPD_CMD, TORQUE;
   flags_s             MOTION_FLAGS;
   int                 failures = 0, compares = 0, seed = 6582;
   int                 md = 0, pm, pd, pc, pf, sa, tqs = 0, sc = 100;
   logic [34:0]        rq[$];
   logic [6:0]         e;
   int sp[10] = '{0, 10, 11, -20, 21, -99, 100, 111, 89, 90};
   int tv[10] = '{0, 95, 100, 95, 89, -100, -91, -90, 0, 300};
   int dv[7] = '{800, 801, -5000, 5001, 0, 0, 0};

   initial forever #50 REF_CLK = ~REF_CLK;
   motion_status_comparators #(.CYCLES_PER_MS(10)) u_motion_status_comparators (.*);
   servo_loop_model u_servo_loop_model (.*);

   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic check(input logic [34:0] got, input logic [34:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, got, exp);
      end
   endtask : check

   always @(posedge REF_CLK) begin
      if (RVALID && RREADY) check({IRQ, RRESP, RDATA}, rq.pop_front());
      if (BVALID && BREADY) check({33'h0, BRESP}, {33'h0, bq.pop_front()});
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      @(posedge REF_CLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge REF_CLK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      BREADY <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({irq_exp, r, d});
      @(posedge REF_CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge REF_CLK);
         if (ARREADY) ARVALID <= 1'b0;
      end while (!RVALID);
      RREADY <= 1'b0;
   endtask : rd

   function automatic int ab(input int x);
      return x < 0 ? -x : x;
   endfunction : ab

   // expected flags with every threshold at its reset default
   function automatic logic [6:0] fx();
      logic ok;
      ok = (md == 1) ? (pc == 0) : (md >= 2) ? (pf == 0) : 1'b1;
      ok = ok && pm != 0;
      return {tqs[0], ab(sa) <= 10, ab(sa) >= 100, ab(sa - sc) <= 10, ab(sa) > 20,
              ok && ab(pd) <= 5000, ok && ab(pd) <= 800};
   endfunction : fx

   task automatic go(input int m, d, c, f, s, t);
      pm = m;
      pd = d;
      pc = c;
      pf = f;
      sa = s;
      if (ab(t) >= 100) tqs = 1;
      else if (ab(t) < 90) tqs = 0;
      u_servo_loop_model.set(m, d, c, f, s, sc, t);
      repeat (3) @(posedge REF_CLK);
   endtask : go

   task automatic rdf(input logic [6:0] x);
      rd(OFF_FLAGS, {25'h0, x}, RESP_OKAY);
   endtask : rdf

   task automatic rd_defaults();
      for (int i = 0; i < 11; i++)
         rd(8'(4 * i), {16'h0, PARAM_RST[i]}, RESP_OKAY);
   endtask : rd_defaults

   task automatic report_and_stop();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (20000) @(posedge REF_CLK);
      failures++;
      report_and_stop();
   end

   initial begin
      repeat (2) @(posedge REF_CLK);
      RST <= 1'b0;
      rd_defaults();
      rd(8'h3c, 32'h0, RESP_SLVERR);
      rd(OFF_IRQ_CLEAR, 32'h0, RESP_OKAY);
      wr(8'h3c, 32'h1, RESP_SLVERR);
      wr(OFF_FLAGS, 32'h7f, RESP_SLVERR);
      for (int i = 1; i < 11; i++) begin
         v = $random(seed);
         wr(8'(4 * i), v, RESP_OKAY);
         rd(8'(4 * i), {16'h0, v[15:0]}, RESP_OKAY);
      end
      // reset in mid-run must bring every threshold back
      @(posedge REF_CLK);
      RST <= 1'b1;
      @(posedge REF_CLK);
      RST <= 1'b0;
      rd_defaults();
      for (int j = 0; j < 10; j++) begin
         go(0, 0, 0, 0, sp[j], tv[j]);
         rdf(fx());
      end
      for (int m = 0; m < 3; m++) begin
         md = m;
         wr(8'h00, 32'(m), RESP_OKAY);
         for (int j = 0; j < 7; j++) begin
            go(j != 6, dv[j], j == 4 ? $random(seed) | 1 : 0, j == 5 ? $random(seed) | 1 : 0, 0, 0);
            rdf(fx());
         end
      end
      wr(8'(IDX_WIN_MS * 4), 32'h2, RESP_OKAY);
      wr(8'(IDX_HOLD_MS * 4), 32'h3, RESP_OKAY);
      md = 3;
      wr(8'h00, 32'h3, RESP_OKAY);
      go(1, 0, 0, 0, 0, 0);
      e = fx();
      e[1:0] = 2'b00;
      rdf(e);
      repeat (40) @(posedge REF_CLK);
      e[1:0] = 2'b11;
      rdf(e);
      go(1, 0, 0, 5, 0, 0);
      rdf(e);
      repeat (60) @(posedge REF_CLK);
      e[1:0] = 2'b00;
      rdf(e);
      // interrupt: standstill and rotating edges become sticky status
      go(0, 0, 0, 0, 50, 0);
      wr(OFF_IRQ_ENABLE, 32'h20, RESP_OKAY);
      wr(OFF_IRQ_CLEAR, 32'h7f, RESP_OKAY);
      rd(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
      go(0, 0, 0, 0, 0, 0);
      go(0, 0, 0, 0, 50, 0);
      irq_exp = 1'b1;
      rd(OFF_IRQ_STATUS, 32'h24, RESP_OKAY);
      rd(OFF_IRQ_ENABLE, 32'h20, RESP_OKAY);
      wr(OFF_IRQ_ENABLE, 32'h0, RESP_OKAY);
      irq_exp = 1'b0;
      rd(OFF_IRQ_STATUS, 32'h24, RESP_OKAY);
      wr(OFF_IRQ_ENABLE, 32'h20, RESP_OKAY);
      wr(OFF_IRQ_CLEAR, 32'h20, RESP_OKAY);
      rd(OFF_IRQ_STATUS, 32'h04, RESP_OKAY);
      WSTRB <= 4'h2;
      wr(8'h04, 32'h1234, RESP_OKAY);
      rd(8'h04, 32'h1220, RESP_OKAY);
      @(posedge REF_CLK) report_and_stop();
   end
endmodule : motion_status_comparators_tb
